// File: hw/hcs_pkg.sv
// Package holding offsets, field positions, reset values and timing of the host control bank.
`default_nettype none
package hcs_pkg;
	localparam logic [3:0] ADDR_SUBSYS_RST = 4'h0;
	localparam logic [3:0] ADDR_IRQ_PANEL  = 4'h2;
	localparam logic [3:0] ADDR_ENG_STAT   = 4'h2;
	localparam logic [3:0] ADDR_CLK_DIO    = 4'h4;
	localparam logic [3:0] ADDR_CARD_IN    = 4'h6;
	localparam logic [3:0] ADDR_RX_STAT    = 4'h6;
	localparam logic [3:0] ADDR_SW_STAT    = 4'h8;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam int         BIT_HMR         = 7;
	localparam int         BIT_MUTE_N      = 5;
	localparam int         BIT_VIEW_SEL    = 5;
	localparam logic [1:0] WCS_INT_44K1    = 2'h0;
	localparam logic [1:0] WCS_INT_48K     = 2'h1;
	localparam logic [1:0] WCS_EXTERNAL    = 2'h2;
	localparam logic [1:0] WCS_DISABLED    = 2'h3;
	localparam int         CLK_HZ          = 50000000;
	localparam real        POR_DELAY_S     = 0.75;
	localparam int         POR_CYCLES      = int'(POR_DELAY_S * CLK_HZ);
	localparam int         WDOG_CYCLES     = 100000;
	localparam int         PULSE_CYCLES    = 1000;
	localparam int         HMR_CLR_CYCLES  = 16;
endpackage
`default_nettype wire

// File: hw/hcs_if.sv
// Interface joining the host CPU I/O bus to the control and status bank.
`timescale 1ns/1ps
`default_nettype none
interface hcs_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       wr;
	logic       rd;
	logic       kick;
	modport dev (input addr, input wdata, input wr, input rd, input kick,
		output rdata);
	modport host (output addr, output wdata, output wr, output rd,
		output kick, input rdata);
endinterface
`default_nettype wire

// File: hw/hcs_host.sv
// Host end: takes AXI4-Lite orders and runs single I/O cycles on the bank.
`timescale 1ns/1ps
`default_nettype none
module hcs_host
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	hcs_if.host              io,
	input  wire logic [31:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [31:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	// ---------------------------------------------------------------
	// Own map: word n at byte 4n is bank location n; word 0x10 kicks.
	// ---------------------------------------------------------------
	localparam logic [7:0] KICK_WORD = 8'h10;
	typedef struct packed {
		logic       aw_got;
		logic       w_got;
		logic [7:0] awa;
		logic [7:0] wd;
		logic       bv;
		logic [1:0] bresp;
		logic       rv;
		logic [7:0] rd;
		logic       wr;
		logic       kick;
		logic       rdp;
		logic [3:0] addr;
		logic [7:0] data;
	} hcs_hst_t;
	hcs_hst_t s_q;
	hcs_hst_t s_d;
	always_comb
	begin
		s_d = s_q;
		s_d.wr = 1'b0;
		s_d.kick = 1'b0;
		s_d.rdp = 1'b0;
		if (s_awvalid && s_awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.awa = s_awaddr[9:2];
		end
		if (s_wvalid && s_wready)
		begin
			s_d.w_got = 1'b1;
			s_d.wd = s_wdata[7:0];
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bv)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bv = 1'b1;
			s_d.bresp = 2'h0;
			if (s_q.awa == KICK_WORD)
				s_d.kick = 1'b1;
			else if (s_q.awa < 8'h10)
			begin
				s_d.wr = 1'b1;
				s_d.addr = s_q.awa[3:0];
				s_d.data = s_q.wd;
			end
			else
				s_d.bresp = 2'h2;
		end
		if (s_q.bv && s_bready)
			s_d.bv = 1'b0;
		if (s_arvalid && s_arready)
		begin
			s_d.rdp = 1'b1;
			s_d.addr = s_araddr[5:2];
		end
		if (s_q.rdp)
		begin
			s_d.rv = 1'b1;
			s_d.rd = io.rdata;
		end
		if (s_q.rv && s_rready)
			s_d.rv = 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign s_awready = !s_q.aw_got && !s_q.bv;
	assign s_wready  = !s_q.w_got && !s_q.bv;
	assign s_bvalid  = s_q.bv;
	assign s_bresp   = s_q.bresp;
	assign s_arready = !s_q.rv && !s_q.rdp && !(s_q.aw_got && s_q.w_got);
	assign s_rvalid  = s_q.rv;
	assign s_rresp   = 2'h0;
	assign s_rdata   = {24'h000000, s_q.rd};
	assign io.addr   = s_q.addr;
	assign io.wdata  = s_q.data;
	assign io.wr     = s_q.wr;
	assign io.rd     = s_q.rdp;
	assign io.kick   = s_q.kick;
endmodule
`default_nettype wire

// File: hw/hcs_dev.sv
// Device end: control registers, status reads, reset sequencer and watchdog.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Undervoltage forces master reset at once.
// - Power-on waits delay, releases master and host CPU resets.
// - Software releases remaining sub-system resets.
// - Host reset bit fires full reset pulse.
// - Pulse starts on host bit rising edge.
// - Missed kick times out, fires reset.
// - Watchdog idle until first kick.
// - Pulse end reruns power-on release delay.
// - Control registers reset to all zero.
// - Host reset bit self-clears after delay.
// - Software pulses boot mode around DSP release.
// - Mute output starts asserted.
// - Register 0 bit layout.
// - Register 1 bit layout.
// - Register 2 bit layout.
// - Register 3 bit layout.
// - Status 1 bit layout.
// - Status 2 layout with view select.
// - Word-clock source encoding.
// - Software drives converter calibrate sequence.
module hcs_dev
#(
	parameter int POR_CYCLES     = hcs_pkg::POR_CYCLES,
	parameter int WDOG_CYCLES    = hcs_pkg::WDOG_CYCLES,
	parameter int PULSE_CYCLES   = hcs_pkg::PULSE_CYCLES,
	parameter int HMR_CLR_CYCLES = hcs_pkg::HMR_CLR_CYCLES
)
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	hcs_if.dev              io,
	input  wire logic       supply_low,
	output logic            master_reset_n,
	output logic            host_cpu_reset_n,
	output logic            digital_output_valid,
	output logic            mute_n,
	output logic            digital_io_reset_n,
	output logic            force_boot_mode,
	output logic            dsp_reset_n,
	output logic            effects_engine_reset_n,
	output logic            slave_cpu_reset_n,
	output logic            dsp_irq_mask_n,
	output logic            digin_irq_mask_n,
	output logic            panel_led_enable,
	output logic            converter_cal_n,
	output logic [2:0]      irq_priority,
	output logic [1:0]      wordclock_source_select,
	output logic            wordclock_run,
	output logic            wordclock_external,
	output logic            wordclock_48k,
	output logic            receiver_status_view_select,
	output logic [2:0]      tx_chan_status_n,
	output logic [1:0]      tx_frequency_control,
	output logic            card_register_select_n,
	output logic            card_driver_disable_n,
	output logic            professional_input_select,
	output logic            sram_map_select,
	output logic [3:0]      card_page_addr,
	input  wire logic [7:0] engine_flags,
	input  wire logic       pedal_conversion_done_n,
	input  wire logic       receiver_error_flag,
	input  wire logic [5:0] rx_freq_err,
	input  wire logic [5:0] rx_chan_status,
	input  wire logic [7:0] switch_card_flags
);
	// Every phase counter needs at least one cycle to make progress.
	if (POR_CYCLES < 1 || WDOG_CYCLES < 1 || PULSE_CYCLES < 1
		|| HMR_CLR_CYCLES < 1)
	begin
		$error("hcs_dev: timing counts must be at least one");
	end

	// ---------------------------------------------------------------
	// State.
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ST_PULSE, ST_DELAY, ST_RUN} hcs_rst_t;
	typedef struct packed {
		hcs_rst_t    st;
		logic [31:0] cnt;
		logic        armed;
		logic [31:0] wdog;
		logic        hmr_prev;
		logic [31:0] hclr;
		logic [7:0]  c0;
		logic [7:0]  c1;
		logic [7:0]  c2;
		logic [7:0]  c3;
		logic [7:0]  rdata;
	} hcs_dev_t;
	hcs_dev_t s_q;
	hcs_dev_t s_d;
	logic     sys_rst;

	// Control registers are cleared whenever the unit is in master reset.
	// A supply drop counts at once, so no output outlives the reset.
	assign sys_rst = (s_q.st != ST_RUN) || supply_low;

	always_comb
	begin
		s_d = s_q;
		s_d.hmr_prev = s_q.c0[hcs_pkg::BIT_HMR];
		unique case (s_q.st)
			ST_PULSE:
			begin
				if (s_q.cnt >= 32'(PULSE_CYCLES - 1) && !supply_low)
				begin
					s_d.st = ST_DELAY;
					s_d.cnt = '0;
				end
				else if (!supply_low)
					s_d.cnt = s_q.cnt + 32'h1;
			end
			ST_DELAY:
			begin
				if (s_q.cnt >= 32'(POR_CYCLES - 1))
				begin
					s_d.st = ST_RUN;
					s_d.cnt = '0;
				end
				else
					s_d.cnt = s_q.cnt + 32'h1;
			end
			ST_RUN:
				s_d.cnt = '0;
		endcase
		if (sys_rst)
		begin
			s_d.c0 = hcs_pkg::CTRL_RESET;
			s_d.c1 = hcs_pkg::CTRL_RESET;
			s_d.c2 = hcs_pkg::CTRL_RESET;
			s_d.c3 = hcs_pkg::CTRL_RESET;
			s_d.armed = 1'b0;
			s_d.wdog = '0;
			s_d.hclr = '0;
		end
		else
		begin
			if (io.wr)
			begin
				unique case (io.addr)
					hcs_pkg::ADDR_SUBSYS_RST: s_d.c0 = io.wdata;
					hcs_pkg::ADDR_IRQ_PANEL:  s_d.c1 = io.wdata;
					hcs_pkg::ADDR_CLK_DIO:    s_d.c2 = io.wdata;
					hcs_pkg::ADDR_CARD_IN:    s_d.c3 = io.wdata;
					default: ;
				endcase
			end
			if (io.kick)
			begin
				s_d.armed = 1'b1;
				s_d.wdog = '0;
			end
			else if (s_q.armed)
				s_d.wdog = s_q.wdog + 32'h1;
			if (s_q.c0[hcs_pkg::BIT_HMR])
			begin
				if (s_q.hclr >= 32'(HMR_CLR_CYCLES - 1))
				begin
					s_d.c0[hcs_pkg::BIT_HMR] = 1'b0;
					s_d.hclr = '0;
				end
				else
					s_d.hclr = s_q.hclr + 32'h1;
			end
			if ((s_q.c0[hcs_pkg::BIT_HMR] && !s_q.hmr_prev)
				|| (s_q.armed && s_q.wdog >= 32'(WDOG_CYCLES - 1)))
			begin
				s_d.st = ST_PULSE;
				s_d.cnt = '0;
			end
		end
		if (supply_low)
		begin
			s_d.st = ST_PULSE;
			s_d.cnt = '0;
		end
		s_d.rdata = 8'h00;
		if (io.rd)
		begin
			unique case (io.addr)
				hcs_pkg::ADDR_ENG_STAT: s_d.rdata = engine_flags;
				hcs_pkg::ADDR_RX_STAT:
					s_d.rdata = {pedal_conversion_done_n, receiver_error_flag,
						s_q.c2[hcs_pkg::BIT_VIEW_SEL] ? rx_chan_status
						: rx_freq_err};
				hcs_pkg::ADDR_SW_STAT: s_d.rdata = switch_card_flags;
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.st <= ST_DELAY;
		end
		else
			s_q <= s_d;
	end

	// ---------------------------------------------------------------
	// Outputs; reads answer combinationally in the strobe cycle.
	// ---------------------------------------------------------------
	assign io.rdata = (io.rd && io.addr == hcs_pkg::ADDR_RX_STAT)
		? {pedal_conversion_done_n, receiver_error_flag,
		s_q.c2[hcs_pkg::BIT_VIEW_SEL] ? rx_chan_status : rx_freq_err}
		: (io.rd && io.addr == hcs_pkg::ADDR_ENG_STAT) ? engine_flags
		: (io.rd && io.addr == hcs_pkg::ADDR_SW_STAT) ? switch_card_flags
		: s_q.rdata;
	assign master_reset_n              = !sys_rst && !supply_low;
	assign host_cpu_reset_n            = master_reset_n;
	assign digital_output_valid        = s_q.c0[6];
	assign mute_n                      = s_q.c0[hcs_pkg::BIT_MUTE_N];
	assign digital_io_reset_n          = s_q.c0[4];
	assign force_boot_mode             = s_q.c0[3];
	assign dsp_reset_n                 = s_q.c0[2];
	assign effects_engine_reset_n      = s_q.c0[1];
	assign slave_cpu_reset_n           = s_q.c0[0];
	assign dsp_irq_mask_n              = s_q.c1[7];
	assign digin_irq_mask_n            = s_q.c1[6];
	assign panel_led_enable            = s_q.c1[5];
	assign converter_cal_n             = s_q.c1[4];
	assign irq_priority                = s_q.c1[2:0];
	assign wordclock_source_select     = s_q.c2[7:6];
	assign wordclock_run  = (s_q.c2[7:6] != hcs_pkg::WCS_DISABLED);
	assign wordclock_external = (s_q.c2[7:6] == hcs_pkg::WCS_EXTERNAL);
	assign wordclock_48k  = (s_q.c2[7:6] == hcs_pkg::WCS_INT_48K);
	assign receiver_status_view_select = s_q.c2[hcs_pkg::BIT_VIEW_SEL];
	assign tx_chan_status_n            = s_q.c2[4:2];
	assign tx_frequency_control        = s_q.c2[1:0];
	assign card_register_select_n      = s_q.c3[7];
	assign card_driver_disable_n       = s_q.c3[6];
	assign professional_input_select   = s_q.c3[5];
	assign sram_map_select             = s_q.c3[4];
	assign card_page_addr              = s_q.c3[3:0];
endmodule
`default_nettype wire

// File: sim/hcs_props.sv
// Checker for the host control bank: bus strobes and reset sequencing.
`timescale 1ns/1ps
`default_nettype none
module hcs_props
#(
	parameter int POR_CYCLES   = 20,
	parameter int WDOG_CYCLES  = 50,
	parameter int PULSE_CYCLES = 5
)
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       kick,
	input wire logic       supply_low,
	input wire logic       master_reset_n,
	input wire logic       host_cpu_reset_n,
	input wire logic       mute_n,
	input wire logic       dsp_reset_n
);
	// Counters stand in for long repetitions, which would be slow to unroll.
	logic [15:0] low_q;
	logic [15:0] age_q;
	logic        armed_q;
	logic        hmr_q;
	wire         hmr_wr = wr && addr == 4'h0 && wdata[7];

	always_ff @(posedge aclk)
	begin
		low_q   <= (!aresetn || supply_low || master_reset_n) ? 16'h0
			: low_q + 16'h1;
		age_q   <= kick ? 16'h0 : age_q + 16'h1;
		armed_q <= aresetn && master_reset_n && (armed_q || kick);
		hmr_q   <= master_reset_n && (hmr_q || hmr_wr);
	end

	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_undervolt_reset: assert property (supply_low |=> !master_reset_n)
		else $error("reset not forced by low supply");
	a_cpu_release: assert property ($rose(master_reset_n) |->
		$rose(host_cpu_reset_n) && !mute_n && !dsp_reset_n)
		else $error("cpu reset not released alone");
	a_release_delay: assert property ($rose(master_reset_n) |->
		low_q >= POR_CYCLES && low_q <= POR_CYCLES + PULSE_CYCLES + 4)
		else $error("release delay wrong");
	a_hmr_pulse: assert property (hmr_wr && master_reset_n |->
		##[1:3] !master_reset_n) else $error("no pulse on host reset bit");
	a_wdog_idle: assert property ($fell(master_reset_n) |-> armed_q ||
		hmr_q || supply_low || $past(supply_low))
		else $error("reset without cause");
	a_wdog_timeout: assert property (armed_q &&
		age_q == WDOG_CYCLES - 1 |-> ##[1:3] !master_reset_n)
		else $error("watchdog did not expire");
	a_regs_cleared: assert property (!master_reset_n ##1
		!master_reset_n |-> !mute_n && !dsp_reset_n)
		else $error("outputs not cleared in reset");
	a_mute_write: assert property (wr && addr == 4'h0 && !wdata[7] &&
		master_reset_n |=> mute_n == $past(wdata[5]))
		else $error("mute not written");
	a_strobe_pulse: assert property (wr |=> !wr)
		else $error("write strobe too long");

	c_hmr: cover property (hmr_wr && master_reset_n);
	c_release: cover property ($rose(master_reset_n));
	c_kick: cover property (kick && master_reset_n);
endmodule
`default_nettype wire

// File: sim/hcs_test.sv
// Testbench joining both ends of the host control bank over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
 err_count++; $display("Error %s expected %h seen %h", nm, e, s); end end
module host_control_status_and_reset_test;
	localparam int POR = 20;
	localparam int WD = 50;
	localparam int PU = 5;
	int err_count = 0;
	int n_compared = 0;
	logic aclk, aresetn, supply_low, pedal_conversion_done_n;
	logic receiver_error_flag, master_reset_n, host_cpu_reset_n, mute_n;
	logic digital_output_valid, digital_io_reset_n, force_boot_mode;
	logic dsp_reset_n, effects_engine_reset_n, slave_cpu_reset_n;
	logic dsp_irq_mask_n, digin_irq_mask_n, panel_led_enable;
	logic converter_cal_n, wordclock_run, wordclock_external, wordclock_48k;
	logic receiver_status_view_select, card_register_select_n;
	logic card_driver_disable_n, professional_input_select, sram_map_select;
	logic [7:0] engine_flags, switch_card_flags;
	logic [5:0] rx_freq_err, rx_chan_status;
	logic [2:0] irq_priority, tx_chan_status_n;
	logic [1:0] wordclock_source_select, tx_frequency_control;
	logic [1:0] s_bresp, s_rresp;
	logic [3:0] card_page_addr, s_wstrb;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	wire [6:0] o0 = {digital_output_valid, mute_n, digital_io_reset_n,
		force_boot_mode, dsp_reset_n, effects_engine_reset_n,
		slave_cpu_reset_n};
	wire [6:0] o1 = {dsp_irq_mask_n, digin_irq_mask_n, panel_led_enable,
		converter_cal_n, irq_priority};
	wire [7:0] o2 = {wordclock_source_select, receiver_status_view_select,
		tx_chan_status_n, tx_frequency_control};
	wire [7:0] o3 = {card_register_select_n, card_driver_disable_n,
		professional_input_select, sram_map_select, card_page_addr};
	wire [2:0] wclk = {wordclock_run, wordclock_external, wordclock_48k};

	hcs_if io();
	hcs_host u_hcs_host (.*);
	hcs_dev #(.POR_CYCLES(POR), .WDOG_CYCLES(WD), .PULSE_CYCLES(PU),
		.HMR_CLR_CYCLES(4)) u_hcs_dev (.*);
	hcs_props #(.POR_CYCLES(POR), .WDOG_CYCLES(WD), .PULSE_CYCLES(PU))
		u_hcs_props (.aclk(aclk), .aresetn(aresetn), .addr(io.addr),
		.wdata(io.wdata), .wr(io.wr), .kick(io.kick),
		.supply_low(supply_low), .master_reset_n(master_reset_n),
		.host_cpu_reset_n(host_cpu_reset_n), .mute_n(mute_n),
		.dsp_reset_n(dsp_reset_n));

	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Bus, wait and end-of-test tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic bail;
		err_count++;
		$display("Error wait expected answer seen timeout");
		end_of_test();
	endtask

	// Ready is sampled at the falling edge so it is settled before use.
	task automatic axi_wr(input logic [31:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic ta, tw, tb;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= {24'h0, d};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		repeat (40)
		begin
			@(negedge aclk);
			ta = s_awvalid && s_awready;
			tw = s_wvalid && s_wready;
			tb = s_bvalid;
			if (tb) `CHK("bresp", er, s_bresp)
			@(posedge aclk);
			if (ta) s_awvalid <= 1'b0;
			if (tw) s_wvalid <= 1'b0;
			if (tb)
			begin
				s_bready <= 1'b0;
				return;
			end
		end
		bail();
	endtask

	task automatic axi_rd(input logic [31:0] a, input logic [31:0] e,
		input string nm);
		logic ta, tr;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		repeat (40)
		begin
			@(negedge aclk);
			ta = s_arvalid && s_arready;
			tr = s_rvalid;
			if (tr) `CHK(nm, e, s_rdata)
			if (tr) `CHK("rresp", 2'h0, s_rresp)
			@(posedge aclk);
			if (ta) s_arvalid <= 1'b0;
			if (tr)
			begin
				s_rready <= 1'b0;
				return;
			end
		end
		bail();
	endtask

	task automatic wait_up;
		repeat (200)
		begin
			@(negedge aclk);
			if (master_reset_n === 1'b1) return;
		end
		bail();
	endtask

	task automatic watch(input int n, output logic fell);
		fell = 1'b0;
		repeat (n)
		begin
			@(negedge aclk);
			if (master_reset_n !== 1'b1) fell = 1'b1;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ctrl;
		logic [7:0] p;
		p = 8'h5a;
		repeat (2)
		begin
			axi_wr(32'h0, p & 8'h7f, 2'h0);
			axi_wr(32'h8, p, 2'h0);
			axi_wr(32'h10, p, 2'h0);
			axi_wr(32'h18, p, 2'h0);
			@(negedge aclk);
			`CHK("reg0", p[6:0], o0)
			`CHK("reg1", {p[7:4], p[2:0]}, o1)
			`CHK("reg2", p, o2)
			`CHK("reg3", p, o3)
			p = ~p;
		end
		for (int c = 0; c < 4; c++)
		begin
			axi_wr(32'h10, {c[1:0], 6'h0}, 2'h0);
			@(negedge aclk);
			`CHK("wclk", {c != 3, c == 2, c == 1}, wclk)
		end
		axi_wr(32'h100, 8'h00, 2'h2);
	endtask

	// Software brings the sub-systems out of reset in start-up order.
	task automatic t_boot;
		`CHK("cal_low", 1'b0, converter_cal_n)
		axi_wr(32'h0, 8'h08, 2'h0);
		@(negedge aclk);
		`CHK("boot_hold", 7'h08, o0)
		axi_wr(32'h0, 8'h3f, 2'h0);
		@(negedge aclk);
		`CHK("boot_rel", 7'h3f, o0)
		axi_wr(32'h0, 8'h37, 2'h0);
		@(negedge aclk);
		`CHK("boot_done", 7'h37, o0)
		axi_wr(32'h8, 8'h10, 2'h0);
		@(negedge aclk);
		`CHK("cal_high", 1'b1, converter_cal_n)
		axi_wr(32'h8, 8'h00, 2'h0);
		@(negedge aclk);
		`CHK("cal_pulse", 1'b0, converter_cal_n)
	endtask

	task automatic t_status;
		@(posedge aclk);
		engine_flags <= 8'hc3;
		pedal_conversion_done_n <= 1'b0;
		receiver_error_flag <= 1'b1;
		rx_freq_err <= 6'h15;
		rx_chan_status <= 6'h2a;
		switch_card_flags <= 8'h96;
		axi_rd(32'h8, 32'hc3, "stat1");
		axi_rd(32'h8, 32'hc3, "stat1_again");
		axi_rd(32'h18, 32'h55, "stat2_err");
		axi_wr(32'h10, 8'h20, 2'h0);
		axi_rd(32'h18, 32'h6a, "stat2_cs");
		axi_rd(32'h20, 32'h96, "sw_stat");
	endtask

	task automatic t_resets;
		logic f;
		axi_wr(32'h0, 8'ha0, 2'h0);
		watch(4, f);
		`CHK("hmr_pulse", 1'b1, f)
		wait_up();
		`CHK("hmr_clear", 7'h0, o0)
		watch(3 * WD, f);
		`CHK("wd_idle", 1'b0, f)
		repeat (4)
		begin
			axi_wr(32'h40, 8'h00, 2'h0);
			watch(WD - 15, f);
			`CHK("wd_kicked", 1'b0, f)
		end
		watch(WD + 10, f);
		`CHK("wd_timeout", 1'b1, f)
		wait_up();
		axi_wr(32'h0, 8'h20, 2'h0);
		@(posedge aclk);
		supply_low <= 1'b1;
		watch(3, f);
		`CHK("undervolt", 1'b1, f)
		@(posedge aclk);
		supply_low <= 1'b0;
		wait_up();
		`CHK("uv_mute", 1'b0, mute_n)
	endtask

	initial
	begin
		{aresetn, supply_low, pedal_conversion_done_n} = 3'h1;
		{receiver_error_flag, engine_flags, switch_card_flags} = 17'h0;
		{rx_freq_err, rx_chan_status, s_awaddr, s_wdata} = 76'h0;
		{s_araddr, s_awvalid, s_wvalid, s_bready} = 35'h0;
		{s_arvalid, s_rready} = 2'h0;
		s_wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wait_up();
		`CHK("ctrl_clear", 30'h0, {o0, o1, o2, o3})
		`CHK("cpu_rst", 1'b1, host_cpu_reset_n)
		t_boot();
		t_ctrl();
		t_status();
		t_resets();
		end_of_test();
	end
endmodule
`default_nettype wire
